/* design/lcs_consts.svh */
// Constants for the lockstep compare unit
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH
`define LCS_DW 8
`define LCS_CW 16
`define LCS_NBYTE 2
`define LCS_EN_BIT 0
`define LCS_INV_BIT 0
`define LCS_IDLE_PRIM 8'h00
`define LCS_IDLE_RED 8'h01
`define LCS_PAT 8'h5a
`define LCS_CTRL_RST 16'h0001
`define LCS_PAR_RST 2'h1
`endif

/* design/lcs_lockstep_compare_unit.sv */
// Lockstep compare unit with comparator self-test, error forcing and register parity
`timescale 1ns/100ps
`include "lcs_consts.svh"

module lcs_lockstep_compare_unit
   import lcs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [`LCS_DW-1:0] primaryOut,
   input wire logic [`LCS_DW-1:0] redundantOut,
   input wire logic debugConnected,
   input wire logic cfgWrite,
   input wire logic [`LCS_CW-1:0] cfgWrData,
   input wire logic forceErrA,
   input wire logic forceErrB,
   input wire logic selfTestStart,
   input wire logic statusClear,
   input wire logic parityInjectEn,
   input wire logic [`LCS_NBYTE-1:0] parityInjectByte,
   output logic [`LCS_CW-1:0] ctrlReg,
   output logic compareError,
   output logic compareFailFlag,
   output logic parityError,
   output logic registerParityErrorFlag,
   output logic nmiRequest,
   output logic selfTestBusy,
   output logic selfTestDone,
   output logic selfTestPass
);

   // Returns high when the two inputs differ
   function automatic logic mismatch(input logic [`LCS_DW-1:0] a, input logic [`LCS_DW-1:0] b);
      mismatch = (a != b);
   endfunction

   // Even parity per byte of the control register
   function automatic logic [`LCS_NBYTE-1:0] byteParity(input logic [`LCS_CW-1:0] d);
      logic [`LCS_NBYTE-1:0] p;
      p = '0;
      for (int i = 0; i < `LCS_NBYTE; i++)
      begin
         p[i] = ^d[i*8 +: 8];
      end
      byteParity = p;
   endfunction

   lcs_state_t state;
   logic [`LCS_NBYTE-1:0] parityBits;
   logic [1:0] forceActive;
   logic [1:0] forcePrev;
   logic stFail;
   logic compareEnable;
   logic [`LCS_DW-1:0] stPrim;
   logic [`LCS_DW-1:0] stRed;
   logic [1:0] underTest;
   logic [`LCS_DW-1:0] cmpPrim [2];
   logic [`LCS_DW-1:0] cmpRed [2];
   logic [1:0] cmpMism;
   logic next_compareError;

   // Debugger presence overrides the software enable
   assign compareEnable = ctrlReg[`LCS_EN_BIT] & ~debugConnected;

   // Self-test pattern source; idle pair lets a stuck select be seen
   always_comb
   begin
      stPrim = `LCS_IDLE_PRIM;
      stRed = `LCS_IDLE_RED;
      underTest = 2'b00;
      unique case (state)
         ST_IDLE:
         begin
            stPrim = `LCS_IDLE_PRIM;
         end
         ST_A_MATCH, ST_B_MATCH:
         begin
            stPrim = `LCS_PAT;
            stRed = `LCS_PAT;
         end
         ST_A_MISM, ST_B_MISM:
         begin
            stPrim = `LCS_PAT;
            stRed = ~`LCS_PAT;
         end
      endcase
      underTest[0] = (state == ST_A_MATCH) || (state == ST_A_MISM);
      underTest[1] = (state == ST_B_MATCH) || (state == ST_B_MISM);
   end

   // Input select and compare for both comparator copies
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         cmpPrim[i] = underTest[i] ? stPrim : primaryOut;
         cmpRed[i] = underTest[i] ? stRed : redundantOut;
         cmpPrim[i][`LCS_INV_BIT] = cmpPrim[i][`LCS_INV_BIT] ^ forceActive[i];
         cmpMism[i] = mismatch(cmpPrim[i], cmpRed[i]);
      end
   end

   // The copy under test is masked; the other still guards the pair
   assign next_compareError = compareEnable & |(cmpMism & ~underTest);

   // Force edge detect: a held request still forces only one cycle
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         forcePrev <= 2'b00;
         forceActive <= 2'b00;
      end
      else
      begin
         forcePrev <= {forceErrB, forceErrA};
         forceActive <= {forceErrB, forceErrA} & ~forcePrev & {2{compareEnable}};
      end
   end

   // Compare error and sticky fail flag; a new failure beats a clear
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         compareError <= 1'b0;
         compareFailFlag <= 1'b0;
      end
      else
      begin
         compareError <= next_compareError;
         if (next_compareError)
         begin
            compareFailFlag <= 1'b1;
         end
         else if (statusClear)
         begin
            compareFailFlag <= 1'b0;
         end
      end
   end

   // Comparator self-test sequencer, one cycle per test step
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= ST_IDLE;
         selfTestBusy <= 1'b0;
         selfTestDone <= 1'b0;
         selfTestPass <= 1'b0;
         stFail <= 1'b0;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               if (selfTestStart)
               begin
                  state <= ST_A_MATCH;
                  selfTestBusy <= 1'b1;
                  selfTestDone <= 1'b0;
                  selfTestPass <= 1'b0;
                  stFail <= 1'b0;
               end
            end
            ST_A_MATCH:
            begin
               stFail <= stFail | cmpMism[0];
               state <= ST_A_MISM;
            end
            ST_A_MISM:
            begin
               stFail <= stFail | ~cmpMism[0];
               state <= ST_B_MATCH;
            end
            ST_B_MATCH:
            begin
               stFail <= stFail | cmpMism[1];
               state <= ST_B_MISM;
            end
            ST_B_MISM:
            begin
               state <= ST_IDLE;
               selfTestBusy <= 1'b0;
               selfTestDone <= 1'b1;
               selfTestPass <= ~(stFail | ~cmpMism[1]);
               stFail <= stFail | ~cmpMism[1];
            end
         endcase
      end
   end

   // Monitored control register with parity refreshed on each write
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrlReg <= `LCS_CTRL_RST;
         parityBits <= `LCS_PAR_RST;
      end
      else if (cfgWrite)
      begin
         ctrlReg <= cfgWrData;
         parityBits <= byteParity(cfgWrData);
      end
   end

   // Continuous parity check; injection inverts the expected bit of chosen bytes while enabled, the stored bits stay as written
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         parityError <= 1'b0;
         registerParityErrorFlag <= 1'b0;
      end
      else
      begin
         parityError <= |(byteParity(ctrlReg) ^ parityBits ^
                          (parityInjectByte & {`LCS_NBYTE{parityInjectEn}}));
         if (parityError)
         begin
            registerParityErrorFlag <= 1'b1;
         end
         else if (statusClear)
         begin
            registerParityErrorFlag <= 1'b0;
         end
      end
   end

   // NMI toward the aggregator from any latched fault
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         nmiRequest <= 1'b0;
      end
      else
      begin
         nmiRequest <= compareFailFlag | registerParityErrorFlag | (selfTestDone & stFail);
      end
   end

   property p_force_one;
      @(posedge sys_clk) disable iff (sys_rst) forceActive[0] |=> !forceActive[0];
   endproperty
   a_force_one: assert property (p_force_one) else $error("forcing lasted more than one cycle");

   property p_force_err;
      @(posedge sys_clk) disable iff (sys_rst)
         (forceActive[1] && compareEnable && !underTest[1] && primaryOut == redundantOut) |=> compareError;
   endproperty
   a_force_err: assert property (p_force_err) else $error("forced mismatch gave no compare error");

   property p_debug_off;
      @(posedge sys_clk) disable iff (sys_rst) debugConnected |=> !compareError;
   endproperty
   a_debug_off: assert property (p_debug_off) else $error("compare error while debugger connected");

   property p_fail_nmi;
      @(posedge sys_clk) disable iff (sys_rst) compareError |-> compareFailFlag ##1 nmiRequest;
   endproperty
   a_fail_nmi: assert property (p_fail_nmi) else $error("compare error not flagged or no NMI");

   property p_write_parity;
      @(posedge sys_clk) disable iff (sys_rst)
         (cfgWrite && !parityInjectEn) ##1 (!cfgWrite && !parityInjectEn) |=> !parityError;
   endproperty
   a_write_parity: assert property (p_write_parity) else $error("parity error after clean write");

   property p_inject;
      @(posedge sys_clk) disable iff (sys_rst)
         (parityInjectEn && parityInjectByte != '0) |=> parityError ##1 registerParityErrorFlag ##1 nmiRequest;
   endproperty
   a_inject: assert property (p_inject) else $error("parity injection not reported");

   property p_selftest_len;
      @(posedge sys_clk) disable iff (sys_rst)
         (selfTestStart && state == ST_IDLE) |=> selfTestBusy[*4] ##1 (selfTestDone && !selfTestBusy);
   endproperty
   a_selftest_len: assert property (p_selftest_len) else $error("self-test sequence length wrong");

   property p_st_fail_nmi;
      @(posedge sys_clk) disable iff (sys_rst) (selfTestDone && !selfTestPass) |=> nmiRequest;
   endproperty
   a_st_fail_nmi: assert property (p_st_fail_nmi) else $error("self-test failure without NMI");

   property p_idle_pair;
      @(posedge sys_clk) disable iff (sys_rst)
         (state == ST_IDLE) |-> (stPrim == `LCS_IDLE_PRIM && stRed == `LCS_IDLE_RED && underTest == 2'b00);
   endproperty
   a_idle_pair: assert property (p_idle_pair) else $error("idle test source not {0,1}");

endmodule // lcs_lockstep_compare_unit

/* design/lcs_pkg.sv */
// Types for the lockstep compare unit
package lcs_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_A_MATCH, ST_A_MISM, ST_B_MATCH, ST_B_MISM} lcs_state_t;
endpackage

/* verif/lcs_lockstep_pair_model.sv */
// Behavioural model of the primary and redundant processing modules
`timescale 1ns/100ps

module lcs_lockstep_pair_model (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] flipMask,
   output logic [7:0] primaryOut,
   output logic [7:0] redundantOut
);
   logic [7:0] work;

   // Both copies run one counting function, so the words keep changing
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         work <= 8'h00;
      end
      else
      begin
         work <= work + 8'h01;
      end
   end

   // Only the spare copy is upset, the way a transient fault would strike one side
   assign primaryOut = work;
   assign redundantOut = work ^ flipMask;
endmodule // lcs_lockstep_pair_model

/* verif/tb_lcs_lockstep_compare_unit.sv */
// Self-checking bench for the lockstep compare unit
`timescale 1ns/100ps
`include "lcs_consts.svh"

module tb_lcs_lockstep_compare_unit;
   logic sys_clk, sys_rst, debugConnected, cfgWrite, forceErrA, forceErrB, selfTestStart, statusClear;
   logic parityInjectEn, compareError, compareFailFlag, parityError, registerParityErrorFlag;
   logic nmiRequest, selfTestBusy, selfTestDone, selfTestPass;
   logic [15:0] cfgWrData, ctrlReg;
   logic [1:0] parityInjectByte;
   logic [7:0] flipMask, primaryOut, redundantOut;
   int n_mismatch, n_compared;

   lcs_lockstep_pair_model u_lcs_lockstep_pair_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .flipMask(flipMask), .primaryOut(primaryOut), .redundantOut(redundantOut));

   lcs_lockstep_compare_unit u_lcs_lockstep_compare_unit (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .primaryOut(primaryOut), .redundantOut(redundantOut), .debugConnected(debugConnected),
      .cfgWrite(cfgWrite), .cfgWrData(cfgWrData), .forceErrA(forceErrA), .forceErrB(forceErrB),
      .selfTestStart(selfTestStart), .statusClear(statusClear), .parityInjectEn(parityInjectEn),
      .parityInjectByte(parityInjectByte), .ctrlReg(ctrlReg), .compareError(compareError),
      .compareFailFlag(compareFailFlag), .parityError(parityError),
      .registerParityErrorFlag(registerParityErrorFlag), .nmiRequest(nmiRequest),
      .selfTestBusy(selfTestBusy), .selfTestDone(selfTestDone), .selfTestPass(selfTestPass));

   // 40 MHz system clock
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] seen);
      n_compared++;
      if (seen !== expv)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, expv, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic end_of_test;
      if (n_mismatch == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Clear sticky flags; the level request lags the flags by one more cycle
   task automatic clr;
      statusClear = 1'b1;
      cyc(1);
      statusClear = 1'b0;
      cyc(1);
      chk("compareFailFlag", 16'h0000, compareFailFlag);
      chk("nmiRequest", 16'h0000, nmiRequest);
   endtask

   task automatic wr_cfg(input logic [15:0] v);
      cfgWrData = v;
      cfgWrite = 1'b1;
      cyc(1);
      cfgWrite = 1'b0;
      chk("ctrlReg", v, ctrlReg);
      chk("parityError", 16'h0000, parityError);
   endtask

   task automatic t_reset;
      chk("ctrlReg", 16'h0001, ctrlReg);
      chk("nmiRequest", 16'h0000, nmiRequest);
      chk("selfTestDone", 16'h0000, selfTestDone);
   endtask

   task automatic t_mismatch;
      flipMask = 8'h80;
      cyc(1);
      flipMask = 8'h00;
      chk("compareError", 16'h0001, compareError);
      chk("compareFailFlag", 16'h0001, compareFailFlag);
      cyc(1);
      chk("compareError", 16'h0000, compareError);
      chk("nmiRequest", 16'h0001, nmiRequest);
      clr();
   endtask

   // Request held high on purpose: the force must still last a single cycle
   task automatic t_force;
      for (int side = 0; side < 2; side++)
      begin
         {forceErrB, forceErrA} = (side == 0) ? 2'b01 : 2'b10;
         cyc(1);
         chk("compareError", 16'h0000, compareError);
         cyc(1);
         chk("compareError", 16'h0001, compareError);
         cyc(1);
         chk("compareError", 16'h0000, compareError);
         chk("compareFailFlag", 16'h0001, compareFailFlag);
         {forceErrB, forceErrA} = 2'b00;
         clr();
      end
   endtask

   // Neither a debugger nor a cleared enable may let an error through
   task automatic t_disabled;
      debugConnected = 1'b1;
      forceErrA = 1'b1;
      flipMask = 8'h01;
      cyc(3);
      chk("compareFailFlag", 16'h0000, compareFailFlag);
      {forceErrA, debugConnected, flipMask} = 10'h000;
      wr_cfg(16'h8000);
      flipMask = 8'h01;
      cyc(2);
      flipMask = 8'h00;
      chk("compareFailFlag", 16'h0000, compareFailFlag);
      wr_cfg(16'h0001);
   endtask

   task automatic t_parity;
      for (int b = 1; b < 3; b++)
      begin
         parityInjectByte = b[1:0];
         parityInjectEn = 1'b1;
         cyc(1);
         chk("parityError", 16'h0001, parityError);
         cyc(1);
         chk("registerParityErrorFlag", 16'h0001, registerParityErrorFlag);
         cyc(1);
         chk("nmiRequest", 16'h0001, nmiRequest);
         chk("compareError", 16'h0000, compareError);
         parityInjectEn = 1'b0;
         // The flag is set from the registered error, so clear only once that has dropped
         cyc(1);
         chk("parityError", 16'h0000, parityError);
         chk("registerParityErrorFlag", 16'h0001, registerParityErrorFlag);
         clr();
         chk("parityError", 16'h0000, parityError);
         chk("registerParityErrorFlag", 16'h0000, registerParityErrorFlag);
      end
   endtask

   // A force landing on comparator A during its match step must fail the self-test
   task automatic t_selftest_fail;
      selfTestStart = 1'b1;
      forceErrA = 1'b1;
      cyc(1);
      selfTestStart = 1'b0;
      forceErrA = 1'b0;
      chk("selfTestBusy", 16'h0001, selfTestBusy);
      cyc(4);
      chk("selfTestDone", 16'h0001, selfTestDone);
      chk("selfTestPass", 16'h0000, selfTestPass);
      cyc(1);
      chk("nmiRequest", 16'h0001, nmiRequest);
   endtask

   // A fault during self-test must still be caught by the comparator not under test
   task automatic t_selftest;
      int k;
      selfTestStart = 1'b1;
      cyc(1);
      selfTestStart = 1'b0;
      chk("selfTestBusy", 16'h0001, selfTestBusy);
      flipMask = 8'h04;
      cyc(1);
      flipMask = 8'h00;
      chk("compareError", 16'h0001, compareError);
      for (k = 0; k < 10 && selfTestDone !== 1'b1; k++)
         cyc(1);
      if (k == 10)
      begin
         n_mismatch++;
         end_of_test();
      end
      chk("selfTestLength", 16'h0003, k[15:0]);
      chk("selfTestPass", 16'h0001, selfTestPass);
      chk("selfTestBusy", 16'h0000, selfTestBusy);
      clr();
   endtask

   // Inputs change only at the falling edge
   initial
   begin
      {debugConnected, cfgWrite, forceErrA, forceErrB, selfTestStart, statusClear, parityInjectEn} = 7'h00;
      {cfgWrData, parityInjectByte, flipMask} = 26'h0;
      n_mismatch = 0;
      n_compared = 0;
      sys_rst = 1'b1;
      cyc(3);
      sys_rst = 1'b0;
      t_reset();
      t_mismatch();
      t_force();
      t_disabled();
      t_parity();
      t_selftest_fail();
      t_selftest();
      end_of_test();
   end
endmodule // tb_lcs_lockstep_compare_unit
